// ### inc/fpmm_defines.svh
// Purpose: constants for the move-multiple and monadic-operation unit
// Assumes: extended values are held as 80 bits {sign, exponent, mantissa}
// Notes: the 96-bit memory image carries 16 zero pad bits at [79:64]
`ifndef FPMM_DEFINES_SVH
`define FPMM_DEFINES_SVH

`define FPMM_NUM_REGS 8
`define FPMM_EXT_W 80
`define FPMM_MEM_W 96
`define FPMM_PAD_W 16
`define FPMM_EXP_W 15
`define FPMM_MAN_W 64
`define FPMM_INT_W 32
`define FPMM_EXP_BIAS 15'h3FFF
`define FPMM_EXP_MAX 15'h7FFF
`define FPMM_MEM_SIGN_BIT 95
`define FPMM_MEM_EXP_HI 94
`define FPMM_MEM_EXP_LO 80
`define FPMM_MEM_MAN_HI 63

`endif

// ### inc/fpmm_pkg.sv
// Purpose: types for the move-multiple and monadic-operation unit
// Assumes: constants come from fpmm_defines.svh
// Notes: none
`include "fpmm_defines.svh"

package fpmm_pkg;

	typedef enum logic [4:0] {
		OP_ABSOLUTE_VALUE = 5'h00, OP_NEGATE = 5'h01, OP_SQUARE_ROOT = 5'h02,
		OP_SINE = 5'h03, OP_COSINE = 5'h04, OP_TANGENT = 5'h05,
		OP_ARC_SINE = 5'h06, OP_ARC_COSINE = 5'h07, OP_ARC_TANGENT = 5'h08,
		OP_HYP_SINE = 5'h09, OP_HYP_COSINE = 5'h0A, OP_HYP_TANGENT = 5'h0B,
		OP_HYP_ARC_TANGENT = 5'h0C, OP_E_TO_X = 5'h0D, OP_E_TO_X_MINUS1 = 5'h0E,
		OP_TWO_TO_X = 5'h0F, OP_TEN_TO_X = 5'h10, OP_LOG_E = 5'h11,
		OP_LOG_E_X_PLUS1 = 5'h12, OP_LOG_2 = 5'h13, OP_LOG_10 = 5'h14,
		OP_INTEGER_PART = 5'h15, OP_TRUNCATED_INTEGER_PART = 5'h16,
		OP_EXPONENT_EXTRACT = 5'h17, OP_MANTISSA_EXTRACT = 5'h18,
		OP_OPERAND_TEST = 5'h19, OP_SINE_COSINE_PAIR = 5'h1A
	} fpmm_op_e;

	typedef enum logic [1:0] {
		SRC_FLOAT_REG = 2'h0, SRC_MEMORY = 2'h1, SRC_HOST_REG = 2'h2
	} fpmm_src_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0, ST_MM_READ = 4'h1, ST_MM_OUT = 4'h2, ST_MM_IN = 4'h3,
		ST_MON_ARG = 4'h4, ST_MON_EXEC = 4'h5, ST_MON_EVAL = 4'h6,
		ST_MON_WB = 4'h7, ST_MON_WB2 = 4'h8, ST_DONE = 4'h9
	} fpmm_state_e;

	typedef struct packed {
		logic sign;
		logic [`FPMM_EXP_W-1:0] exponent;
		logic [`FPMM_MAN_W-1:0] mantissa;
	} fpmm_ext_s;

	typedef struct packed {
		logic is_move_multiple;
		logic to_memory;
		logic dynamic_mask;
		logic [`FPMM_NUM_REGS-1:0] mask;
		fpmm_op_e op;
		fpmm_src_e src;
		logic [2:0] src_reg;
		logic [2:0] dst_reg;
		logic [2:0] cos_reg;
		logic [`FPMM_MEM_W-1:0] operand;
	} fpmm_cmd_s;

	typedef struct packed {
		logic negative;
		logic zero;
		logic infinity;
		logic not_a_number;
	} fpmm_flags_s;

endpackage

// ### logic/fpmm_regfile.sv
// Purpose: eight extended-precision data registers, one read and one write port
// Assumes: read data appear one cycle after the read strobe
// Notes: a write and a read of the same register in one cycle return the old value
`timescale 1ns/1ps
`include "fpmm_defines.svh"

module fpmm_regfile (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Read port
	input wire logic rd_en,
	input wire logic [2:0] rd_addr,
	output fpmm_pkg::fpmm_ext_s rd_data,
	// Write port
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input fpmm_pkg::fpmm_ext_s wr_data
);

	typedef struct packed {
		logic [`FPMM_NUM_REGS-1:0][`FPMM_EXT_W-1:0] mem;
		logic [`FPMM_EXT_W-1:0] rdata;
	} fpmm_rf_s;

	fpmm_rf_s s_q;
	fpmm_rf_s s_d;

	always_comb begin
		s_d = s_q;
		if (rd_en) begin
			s_d.rdata = s_q.mem[rd_addr];
		end
		if (wr_en) begin
			s_d.mem[wr_addr] = wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data = fpmm_pkg::fpmm_ext_s'(s_q.rdata);

endmodule

// ### logic/fpmm_core.sv
// Purpose: move-multiple transfers and monadic-operation sequencing
// Assumes: host decodes the instruction into a command; evaluator is on the same clock
// Notes: simple monadic ops run inline, the rest go to the external evaluator
`timescale 1ns/1ps
`include "fpmm_defines.svh"

module fpmm_core (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// Command from host
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input fpmm_pkg::fpmm_cmd_s CMD,
	input wire logic [`FPMM_INT_W-1:0] HOST_DREG,
	output logic CMD_DONE,
	output fpmm_pkg::fpmm_flags_s TEST_FLAGS,
	// Register images to memory
	output logic MEM_OUT_VALID,
	input wire logic MEM_OUT_READY,
	output logic [`FPMM_MEM_W-1:0] MEM_OUT_DATA,
	// Register images from memory
	input wire logic MEM_IN_VALID,
	output logic MEM_IN_READY,
	input wire logic [`FPMM_MEM_W-1:0] MEM_IN_DATA,
	// Transcendental evaluator
	output logic EVAL_REQ,
	output fpmm_pkg::fpmm_op_e EVAL_OP,
	output fpmm_pkg::fpmm_ext_s EVAL_ARG,
	input wire logic EVAL_ACK,
	input fpmm_pkg::fpmm_ext_s EVAL_RESULT,
	input fpmm_pkg::fpmm_ext_s EVAL_COS_RESULT
);

	typedef struct packed {
		fpmm_pkg::fpmm_state_e st;
		fpmm_pkg::fpmm_cmd_s cmd;
		logic [`FPMM_NUM_REGS-1:0] pending;
		fpmm_pkg::fpmm_ext_s arg;
		fpmm_pkg::fpmm_ext_s res;
		fpmm_pkg::fpmm_ext_s res_cos;
		fpmm_pkg::fpmm_flags_s flags;
		logic done;
	} fpmm_core_s;

	fpmm_core_s s_q;
	fpmm_core_s s_d;

	logic rd_en;
	logic [2:0] rd_addr;
	fpmm_pkg::fpmm_ext_s rd_data;
	logic wr_en;
	logic [2:0] wr_addr;
	fpmm_pkg::fpmm_ext_s wr_data;
	logic [2:0] next_reg;

	// Lowest selected register
	function automatic logic [2:0] lowest_reg(input logic [`FPMM_NUM_REGS-1:0] m);
		logic [2:0] r;
		r = 3'h0;
		for (int i = `FPMM_NUM_REGS - 1; i >= 0; i--) begin
			if (m[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	// Signed integer to extended, exact
	function automatic fpmm_pkg::fpmm_ext_s int_to_ext(input logic [`FPMM_INT_W-1:0] v);
		fpmm_pkg::fpmm_ext_s e;
		logic [`FPMM_INT_W-1:0] mag;
		logic [5:0] msb;
		e = '0;
		mag = v[`FPMM_INT_W-1] ? (~v + 32'h00000001) : v;
		msb = 6'h00;
		for (int i = 0; i < `FPMM_INT_W; i++) begin
			if (mag[i]) begin
				msb = 6'(i);
			end
		end
		if (mag != '0) begin
			e.sign = v[`FPMM_INT_W-1];
			e.exponent = `FPMM_EXP_BIAS + 15'(msb);
			e.mantissa = {32'h00000000, mag} << (6'h3F - msb);
		end
		return e;
	endfunction

	// 96-bit image to register value, pad bits dropped
	function automatic fpmm_pkg::fpmm_ext_s mem_to_ext(input logic [`FPMM_MEM_W-1:0] m);
		return {m[`FPMM_MEM_SIGN_BIT], m[`FPMM_MEM_EXP_HI:`FPMM_MEM_EXP_LO],
			m[`FPMM_MEM_MAN_HI:0]};
	endfunction

	fpmm_regfile u_regfile (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data)
	);

	assign next_reg = lowest_reg(s_q.pending);

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		rd_en = 1'b0;
		rd_addr = next_reg;
		wr_en = 1'b0;
		wr_addr = next_reg;
		wr_data = s_q.res;
		case (s_q.st)
			fpmm_pkg::ST_IDLE: begin
				if (CMD_VALID) begin
					s_d.cmd = CMD;
					if (CMD.is_move_multiple) begin
						// Run-time selection from host register
						s_d.pending = CMD.dynamic_mask ? HOST_DREG[`FPMM_NUM_REGS-1:0]
							: CMD.mask;
						if (s_d.pending == '0) begin
							s_d.st = fpmm_pkg::ST_DONE;
						end else if (CMD.to_memory) begin
							s_d.st = fpmm_pkg::ST_MM_READ;
						end else begin
							s_d.st = fpmm_pkg::ST_MM_IN;
						end
					end else begin
						case (CMD.src)
							fpmm_pkg::SRC_FLOAT_REG: begin
								rd_en = 1'b1;
								rd_addr = CMD.src_reg;
								s_d.st = fpmm_pkg::ST_MON_ARG;
							end
							fpmm_pkg::SRC_HOST_REG: begin
								s_d.arg = int_to_ext(CMD.operand[`FPMM_INT_W-1:0]);
								s_d.st = fpmm_pkg::ST_MON_EXEC;
							end
							default: begin
								s_d.arg = mem_to_ext(CMD.operand);
								s_d.st = fpmm_pkg::ST_MON_EXEC;
							end
						endcase
					end
				end
			end
			fpmm_pkg::ST_MM_READ: begin
				rd_en = 1'b1;
				s_d.st = fpmm_pkg::ST_MM_OUT;
			end
			fpmm_pkg::ST_MM_OUT: begin
				if (MEM_OUT_VALID && MEM_OUT_READY) begin
					s_d.pending[next_reg] = 1'b0;
					s_d.st = (s_d.pending == '0) ? fpmm_pkg::ST_DONE : fpmm_pkg::ST_MM_READ;
				end
			end
			fpmm_pkg::ST_MM_IN: begin
				if (MEM_IN_VALID) begin
					wr_en = 1'b1;
					wr_data = mem_to_ext(MEM_IN_DATA);
					s_d.pending[next_reg] = 1'b0;
					if (s_d.pending == '0) begin
						s_d.st = fpmm_pkg::ST_DONE;
					end
				end
			end
			fpmm_pkg::ST_MON_ARG: begin
				s_d.arg = rd_data;
				s_d.st = fpmm_pkg::ST_MON_EXEC;
			end
			fpmm_pkg::ST_MON_EXEC: begin
				s_d.res = s_q.arg;
				s_d.st = fpmm_pkg::ST_MON_WB;
				case (s_q.cmd.op)
					fpmm_pkg::OP_ABSOLUTE_VALUE: begin
						s_d.res.sign = 1'b0;
					end
					fpmm_pkg::OP_NEGATE: begin
						s_d.res.sign = ~s_q.arg.sign;
					end
					fpmm_pkg::OP_EXPONENT_EXTRACT: begin
						s_d.res = (s_q.arg.mantissa == '0) ? s_q.arg
							: int_to_ext(32'(s_q.arg.exponent) - 32'(`FPMM_EXP_BIAS));
					end
					fpmm_pkg::OP_MANTISSA_EXTRACT: begin
						if (s_q.arg.mantissa != '0) begin
							s_d.res.exponent = `FPMM_EXP_BIAS;
						end
					end
					fpmm_pkg::OP_OPERAND_TEST: begin
						s_d.flags.negative = s_q.arg.sign;
						s_d.flags.zero = (s_q.arg.exponent == '0) && (s_q.arg.mantissa == '0);
						s_d.flags.infinity = (s_q.arg.exponent == `FPMM_EXP_MAX)
							&& (s_q.arg.mantissa[`FPMM_MAN_W-2:0] == '0);
						s_d.flags.not_a_number = (s_q.arg.exponent == `FPMM_EXP_MAX)
							&& (s_q.arg.mantissa[`FPMM_MAN_W-2:0] != '0);
						s_d.st = fpmm_pkg::ST_DONE;
					end
					default: begin
						s_d.st = fpmm_pkg::ST_MON_EVAL;
					end
				endcase
			end
			fpmm_pkg::ST_MON_EVAL: begin
				if (EVAL_ACK) begin
					s_d.res = EVAL_RESULT;
					s_d.res_cos = EVAL_COS_RESULT;
					s_d.st = fpmm_pkg::ST_MON_WB;
				end
			end
			fpmm_pkg::ST_MON_WB: begin
				wr_en = 1'b1;
				wr_addr = s_q.cmd.dst_reg;
				s_d.st = (s_q.cmd.op == fpmm_pkg::OP_SINE_COSINE_PAIR)
					? fpmm_pkg::ST_MON_WB2 : fpmm_pkg::ST_DONE;
			end
			fpmm_pkg::ST_MON_WB2: begin
				wr_en = 1'b1;
				wr_addr = s_q.cmd.cos_reg;
				wr_data = s_q.res_cos;
				s_d.st = fpmm_pkg::ST_DONE;
			end
			fpmm_pkg::ST_DONE: begin
				s_d.done = 1'b1;
				s_d.st = fpmm_pkg::ST_IDLE;
			end
			default: begin
				s_d.st = fpmm_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign CMD_READY = (s_q.st == fpmm_pkg::ST_IDLE);
	assign CMD_DONE = s_q.done;
	assign TEST_FLAGS = s_q.flags;
	assign MEM_OUT_VALID = (s_q.st == fpmm_pkg::ST_MM_OUT);
	// Raw image, no rounding and no range checks
	assign MEM_OUT_DATA = {rd_data.sign, rd_data.exponent, `FPMM_PAD_W'(0),
		rd_data.mantissa};
	assign MEM_IN_READY = (s_q.st == fpmm_pkg::ST_MM_IN);
	assign EVAL_REQ = (s_q.st == fpmm_pkg::ST_MON_EVAL);
	assign EVAL_OP = s_q.cmd.op;
	assign EVAL_ARG = s_q.arg;

endmodule

// ### sim/fpmm_core_props.sv
// Purpose: port checks for fpmm_core
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to every fpmm_core instance
`timescale 1ns/1ps
`include "fpmm_defines.svh"

module fpmm_core_props (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// Command side
	input wire logic CMD_VALID,
	input wire logic CMD_READY,
	input fpmm_pkg::fpmm_cmd_s CMD,
	input wire logic CMD_DONE,
	input fpmm_pkg::fpmm_flags_s TEST_FLAGS,
	// Memory and evaluator side
	input wire logic MEM_OUT_VALID,
	input wire logic MEM_OUT_READY,
	input wire logic [`FPMM_MEM_W-1:0] MEM_OUT_DATA,
	input wire logic MEM_IN_READY,
	input wire logic EVAL_REQ,
	input fpmm_pkg::fpmm_ext_s EVAL_ARG,
	input wire logic EVAL_ACK
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	sequence take_s;
		CMD_VALID && CMD_READY;
	endsequence
	sequence empty_mm_s;
		take_s ##0 (CMD.is_move_multiple && !CMD.dynamic_mask && CMD.mask == 8'h00);
	endsequence
	logic in_mm_q;
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			in_mm_q <= 1'b0;
		end else if (CMD_VALID && CMD_READY) begin
			in_mm_q <= CMD.is_move_multiple;
		end else if (CMD_DONE) begin
			in_mm_q <= 1'b0;
		end
	end
	busy_after_take_a: assert property (take_s |=> !CMD_READY)
		else $error("ready high after take");
	done_pulse_a: assert property (CMD_DONE |=> !CMD_DONE) else $error("done too long");
	done_idle_a: assert property (CMD_DONE |-> CMD_READY) else $error("done while busy");
	pad_zero_a: assert property (MEM_OUT_VALID |-> MEM_OUT_DATA[79:64] == 16'h0)
		else $error("pad bits set");
	out_hold_a: assert property (MEM_OUT_VALID && !MEM_OUT_READY
		|=> MEM_OUT_VALID && $stable(MEM_OUT_DATA)) else $error("image changed in stall");
	arg_hold_a: assert property (EVAL_REQ && !EVAL_ACK |=> EVAL_REQ && $stable(EVAL_ARG))
		else $error("operand changed in wait");
	mm_no_flags_a: assert property (in_mm_q |=> $stable(TEST_FLAGS))
		else $error("flags moved in transfer");
	mm_no_eval_a: assert property (in_mm_q |-> !EVAL_REQ) else $error("evaluator in transfer");
	empty_mask_a: assert property (empty_mm_s |-> ##[1:3] CMD_DONE)
		else $error("empty list not done");
	in_only_mm_a: assert property (MEM_IN_READY |-> in_mm_q) else $error("stray receive");
endmodule

bind fpmm_core fpmm_core_props u_props (.REF_CLK(REF_CLK), .RST_N(RST_N),
	.CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD(CMD), .CMD_DONE(CMD_DONE),
	.TEST_FLAGS(TEST_FLAGS), .MEM_OUT_VALID(MEM_OUT_VALID), .MEM_OUT_READY(MEM_OUT_READY),
	.MEM_OUT_DATA(MEM_OUT_DATA), .MEM_IN_READY(MEM_IN_READY), .EVAL_REQ(EVAL_REQ),
	.EVAL_ARG(EVAL_ARG), .EVAL_ACK(EVAL_ACK));

// ### sim/fpmm_eval_model.sv
// Purpose: evaluator model answering after three waiting cycles
// Assumes: request held until acknowledged
// Notes: results are scrambled outside the ack cycle
`timescale 1ns/1ps

module fpmm_eval_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Evaluator port
	input wire logic req,
	input fpmm_pkg::fpmm_ext_s arg,
	output logic ack,
	output fpmm_pkg::fpmm_ext_s res,
	output fpmm_pkg::fpmm_ext_s cos_res
);
	logic [1:0] cnt;
	logic hit;
	assign hit = req && cnt == 2'h2;
	always @(posedge clk) begin
		if (!rst_n || ack) begin
			cnt <= 2'h0;
			ack <= 1'b0;
		end else if (req) begin
			cnt <= cnt + 2'h1;
			ack <= hit;
		end
		res <= {~arg.sign, arg.exponent ^ 15'h1, ~arg.mantissa} ^ {80{!hit}};
		cos_res <= {arg.sign, arg.exponent, arg.mantissa ^ 64'h1} ^ {80{!hit}};
	end
endmodule

// ### sim/tb_fp_move_multiple_and_monadic_ops.sv
// Purpose: self-checking bench for fpmm_core
// Assumes: memory side driven here, evaluator by fpmm_eval_model
// Notes: register contents read back by transfers to memory, single-register except in t_move
`timescale 1ns/1ps
`include "fpmm_defines.svh"

module tb_fp_move_multiple_and_monadic_ops;
	logic REF_CLK = 0, RST_N = 0, CMD_VALID = 0, MEM_OUT_READY = 0, MEM_IN_VALID = 0;
	logic CMD_READY, CMD_DONE, MEM_OUT_VALID, MEM_IN_READY, EVAL_REQ, EVAL_ACK;
	logic [31:0] HOST_DREG = '0;
	logic [95:0] MEM_IN_DATA = '0, MEM_OUT_DATA, got;
	fpmm_pkg::fpmm_cmd_s CMD = '0, c;
	fpmm_pkg::fpmm_flags_s TEST_FLAGS;
	fpmm_pkg::fpmm_op_e EVAL_OP, seen_op;
	fpmm_pkg::fpmm_ext_s EVAL_ARG, EVAL_RESULT, EVAL_COS_RESULT;
	int num_errors = 0, compares = 0, cycles = 0;
	localparam logic [95:0] W0 = 96'h4000_FFFF_C000_0000_0000_0001;
	localparam logic [95:0] W7 = 96'hBFFE_A5A5_8000_0000_0000_00F0;
	localparam logic [95:0] W1 = 96'h3FFF_0F0F_9000_0000_0000_0003;
	localparam logic [95:0] W2 = 96'h0001_1111_8000_0000_0000_0000;

	fpmm_core u_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID),
		.CMD_READY(CMD_READY), .CMD(CMD), .HOST_DREG(HOST_DREG), .CMD_DONE(CMD_DONE),
		.TEST_FLAGS(TEST_FLAGS), .MEM_OUT_VALID(MEM_OUT_VALID), .MEM_OUT_READY(MEM_OUT_READY),
		.MEM_OUT_DATA(MEM_OUT_DATA), .MEM_IN_VALID(MEM_IN_VALID), .MEM_IN_READY(MEM_IN_READY),
		.MEM_IN_DATA(MEM_IN_DATA), .EVAL_REQ(EVAL_REQ), .EVAL_OP(EVAL_OP), .EVAL_ARG(EVAL_ARG),
		.EVAL_ACK(EVAL_ACK), .EVAL_RESULT(EVAL_RESULT), .EVAL_COS_RESULT(EVAL_COS_RESULT));
	fpmm_eval_model u_eval (.clk(REF_CLK), .rst_n(RST_N), .req(EVAL_REQ), .arg(EVAL_ARG),
		.ack(EVAL_ACK), .res(EVAL_RESULT), .cos_res(EVAL_COS_RESULT));

	initial forever #5 REF_CLK = ~REF_CLK;
	always @(posedge REF_CLK) begin
		if (EVAL_REQ) seen_op <= EVAL_OP;
	end
	always @(posedge REF_CLK) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			results();
		end
	end

	function automatic logic [95:0] img(input logic [95:0] x);
		return {x[95:80], 16'h0, x[63:0]};
	endfunction
	function automatic logic [95:0] ev(input logic [95:0] x);
		return {~x[95], x[94:80] ^ 15'h1, 16'h0, ~x[63:0]};
	endfunction
	task check(input logic [95:0] g, e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task results;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task issue;
		CMD <= c;
		CMD_VALID <= 1'b1;
		do @(negedge REF_CLK); while (!CMD_READY);
		@(posedge REF_CLK);
		CMD_VALID <= 1'b0;
	endtask
	task wait_done;
		do @(negedge REF_CLK); while (!CMD_DONE);
		@(posedge REF_CLK);
	endtask
	task feed(input logic [95:0] a, b);
		MEM_IN_VALID <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			MEM_IN_DATA <= i ? b : a;
			do @(negedge REF_CLK); while (!MEM_IN_READY);
			@(posedge REF_CLK);
		end
		MEM_IN_VALID <= 1'b0;
	endtask
	// Holds off ready for a cycle so the image must stand
	task get;
		do @(negedge REF_CLK); while (!MEM_OUT_VALID);
		@(posedge REF_CLK);
		MEM_OUT_READY <= 1'b1;
		@(negedge REF_CLK);
		got = MEM_OUT_DATA;
		@(posedge REF_CLK);
		MEM_OUT_READY <= 1'b0;
	endtask
	task mm(input logic tomem, dyn, input logic [7:0] m);
		c = '0;
		c.is_move_multiple = 1'b1;
		c.to_memory = tomem;
		c.dynamic_mask = dyn;
		c.mask = m;
	endtask
	task rd(input logic [2:0] r);
		mm(1'b1, 1'b0, 8'h01 << r);
		fork issue; get; join
		wait_done;
	endtask
	task mon(input fpmm_pkg::fpmm_op_e op, input fpmm_pkg::fpmm_src_e s,
		input logic [2:0] sr, dr, cr, input logic [95:0] x);
		c = '0;
		c.op = op;
		c.src = s;
		c.src_reg = sr;
		c.dst_reg = dr;
		c.cos_reg = cr;
		c.operand = x;
		issue;
		wait_done;
	endtask

	task t_move;
		mm(1'b0, 1'b0, 8'h81);
		fork issue; feed(W0, W7); join
		wait_done;
		mm(1'b1, 1'b0, 8'h81);
		fork issue; begin
			get;
			check(got, img(W0));
			get;
			check(got, img(W7));
		end join
		wait_done;
		mm(1'b1, 1'b0, 8'h00);
		issue;
		wait_done;
	endtask
	task t_dyn;
		HOST_DREG <= 32'h0000_0006;
		mm(1'b0, 1'b1, 8'h01);
		fork issue; feed(W1, W2); join
		wait_done;
		rd(3'h1);
		check(got, img(W1));
		rd(3'h2);
		check(got, img(W2));
		rd(3'h0);
		check(got, img(W0));
	endtask
	task t_mon;
		mon(fpmm_pkg::OP_NEGATE, fpmm_pkg::SRC_MEMORY, 3'h0, 3'h5, 3'h0, W1);
		rd(3'h5);
		check(got, img(W1 ^ {1'b1, 95'h0}));
		mon(fpmm_pkg::OP_ABSOLUTE_VALUE, fpmm_pkg::SRC_FLOAT_REG, 3'h5, 3'h6, 3'h0, '0);
		rd(3'h6);
		check(got, img(W1));
		mon(fpmm_pkg::OP_NEGATE, fpmm_pkg::SRC_HOST_REG, 3'h0, 3'h7, 3'h0, 96'h1);
		rd(3'h7);
		check(got, 96'hBFFF_0000_8000_0000_0000_0000);
		mon(fpmm_pkg::OP_SQUARE_ROOT, fpmm_pkg::SRC_FLOAT_REG, 3'h0, 3'h4, 3'h0, '0);
		check(96'(seen_op), 96'(fpmm_pkg::OP_SQUARE_ROOT));
		rd(3'h4);
		check(got, ev(W0));
		mon(fpmm_pkg::OP_SINE_COSINE_PAIR, fpmm_pkg::SRC_MEMORY, 3'h0, 3'h2, 3'h3, W7);
		check(96'(seen_op), 96'(fpmm_pkg::OP_SINE_COSINE_PAIR));
		rd(3'h2);
		check(got, ev(W7));
		rd(3'h3);
		check(got, img(W7) ^ 96'h1);
		mon(fpmm_pkg::OP_OPERAND_TEST, fpmm_pkg::SRC_MEMORY, 3'h0, 3'h0, 3'h0, W7);
		check(96'(TEST_FLAGS), 96'h8);
		mon(fpmm_pkg::OP_EXPONENT_EXTRACT, fpmm_pkg::SRC_MEMORY, 3'h0, 3'h1, 3'h0, W0);
		rd(3'h1);
		check(got, 96'h3FFF_0000_8000_0000_0000_0000);
		mon(fpmm_pkg::OP_MANTISSA_EXTRACT, fpmm_pkg::SRC_MEMORY, 3'h0, 3'h0, 3'h0, W7);
		rd(3'h0);
		check(got, 96'hBFFF_0000_8000_0000_0000_00F0);
	endtask

	initial begin
		repeat (10) @(posedge REF_CLK);
		RST_N <= 1'b1;
		t_move;
		t_dyn;
		t_mon;
		results();
	end
endmodule
